// File: src/clk_switch_pkg.sv
// Shared constants, types and register map for the clock switch and sleep-wake block
package clk_switch_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int CPU_STARTUP_US = 10;
   localparam int CPU_STARTUP_CYC = CPU_STARTUP_US * CLK_MHZ;
   localparam int STABLE_WAIT_MS = 4;
   localparam int STABLE_WAIT_CYC = STABLE_WAIT_MS * 1000 * CLK_MHZ;
   localparam logic [10:0] OST_COUNT = 11'h0400;
   localparam logic [3:0] SETTLE_COUNT = 4'h8;
   localparam logic [10:0] CPU_CYC = 11'(CPU_STARTUP_CYC);

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SEC_CTRL = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ADDR_STATE = 8'h10;

   // oscillator_control fields
   localparam int SCS_LSB = 0;
   localparam int STD_BIT = 2;
   localparam int IOS_BIT = 3;
   localparam int IFS_LSB = 4;
   // secondary control fields
   localparam int SEN_BIT = 0;
   localparam int SCA_BIT = 1;
   // interrupt status bits
   localparam int IRQ_SWITCH = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_STABLE = 2;
   localparam int IRQ_W = 3;

   // Reset values
   localparam logic [1:0] SCS_RESET = 2'h0;
   localparam logic [2:0] IFS_RESET = 3'h0;
   localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

   // Select field codes
   localparam logic [1:0] SCS_PRIMARY = 2'h0;
   localparam logic [1:0] SCS_SECONDARY = 2'h1;
   localparam logic [1:0] SCS_INTERNAL = 2'h2;

   // primary_osc_config codes; values below PCFG_DRIVEN are crystals
   localparam logic [2:0] PCFG_LOW_POWER_CRYSTAL = 3'h0;
   localparam logic [2:0] PCFG_MEDIUM_CRYSTAL = 3'h1;
   localparam logic [2:0] PCFG_HIGH_SPEED_CRYSTAL = 3'h2;
   localparam logic [2:0] PCFG_DRIVEN = 3'h3;
   localparam logic [2:0] PCFG_RC = 3'h4;

   typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} src_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

endpackage

// File: src/clock_switch_sleep_wake.sv
// System clock source switching and sleep-wake sequencing with register port
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module clock_switch_sleep_wake
   import clk_switch_pkg::*;
#(
   parameter int STABLE_WAIT = STABLE_WAIT_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire bus_req_s bus_req,
   output logic [31:0] rdata,
   input wire logic [2:0] primary_osc_config,
   input wire logic two_speed_enable,
   input wire logic primary_tick,
   input wire logic secondary_tick,
   input wire logic internal_tick,
   input wire logic sleep_req,
   input wire logic wake_event,
   output logic [1:0] sys_clk_sel,
   output logic core_run,
   output logic periph_run,
   output logic asleep,
   output logic secondary_osc_on,
   output logic [2:0] internal_freq_select,
   output logic irq
);

   typedef enum logic [2:0] {ST_BOOT, ST_RESET_OST, ST_RUN, ST_OST_WAIT, ST_SETTLE, ST_SLEEP,
      ST_WAKE} state_e;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   state_e state_r;
   src_e cur_src_r;
   src_e tgt_src_r;
   src_e want_src;
   logic [1:0] clock_source_select_r;
   logic [2:0] internal_freq_select_r;
   logic secondary_osc_enable_r;
   logic [IRQ_W-1:0] irq_status_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic start_timer_done_r;
   logic internal_osc_stable_r;
   logic secondary_clock_active_r;
   logic [19:0] stable_cnt_r;
   logic stable_run_r;
   logic [10:0] ost_cnt_r;
   logic [3:0] settle_cnt_r;
   logic [10:0] cpu_cnt_r;
   logic ost_need_r;
   logic core_run_r;
   logic periph_run_r;
   logic done_pulse_r;
   src_e done_src_r;
   logic wake_pulse_r;
   logic stable_pulse;
   logic crystal;
   logic tgt_tick;
   logic ost_done;
   logic cpu_done;
   logic [31:0] rdata_r;
   logic wr_osc;
   logic wr_sec;

   assign crystal = (primary_osc_config < PCFG_DRIVEN);
   assign ost_done = (ost_cnt_r == OST_COUNT);
   assign cpu_done = (cpu_cnt_r == CPU_CYC);
   assign wr_osc = bus_req.wr && (bus_req.addr == ADDR_OSC_CTRL);
   assign wr_sec = bus_req.wr && (bus_req.addr == ADDR_SEC_CTRL);
   assign stable_pulse = stable_run_r && (stable_cnt_r == 20'(STABLE_WAIT - 1));

   always_comb begin
      case (clock_source_select_r)
         SCS_SECONDARY: want_src = SRC_SECONDARY;
         SCS_INTERNAL: want_src = SRC_INTERNAL;
         default: want_src = SRC_PRIMARY;
      endcase
   end

   assign tgt_tick = (tgt_src_r == SRC_SECONDARY) ? secondary_tick :
      (tgt_src_r == SRC_INTERNAL) ? internal_tick : primary_tick;

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   // The secondary select only takes when its oscillator is enabled; a request
   // for both bits lands on the internal oscillator.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         clock_source_select_r <= SCS_RESET;
         internal_freq_select_r <= IFS_RESET;
         secondary_osc_enable_r <= 1'b0;
         irq_mask_r <= MASK_RESET;
      end else begin
         if (wr_osc) begin
            internal_freq_select_r <= bus_req.wdata[IFS_LSB +: 3];
            if (bus_req.wdata[SCS_LSB + 1]) begin
               clock_source_select_r <= SCS_INTERNAL;
            end else if (bus_req.wdata[SCS_LSB] && secondary_osc_enable_r) begin
               clock_source_select_r <= SCS_SECONDARY;
            end else begin
               clock_source_select_r <= SCS_PRIMARY;
            end
         end else if (wr_sec) begin
            secondary_osc_enable_r <= bus_req.wdata[SEN_BIT];
            if (!bus_req.wdata[SEN_BIT] && clock_source_select_r == SCS_SECONDARY) begin
               clock_source_select_r <= SCS_PRIMARY;
            end
         end
         if (bus_req.wr && bus_req.addr == ADDR_IRQ_MASK) begin
            irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Switch and sleep sequencer
   // ----------------------------------------------------------------
   // Sleep never touches the select field, so the wake path simply reads it.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= ST_BOOT;
         cur_src_r <= SRC_PRIMARY;
         tgt_src_r <= SRC_PRIMARY;
         ost_cnt_r <= 11'h000;
         settle_cnt_r <= 4'h0;
         cpu_cnt_r <= 11'h000;
         ost_need_r <= 1'b0;
         core_run_r <= 1'b0;
         periph_run_r <= 1'b0;
         done_pulse_r <= 1'b0;
         done_src_r <= SRC_PRIMARY;
         wake_pulse_r <= 1'b0;
      end else begin
         done_pulse_r <= 1'b0;
         wake_pulse_r <= 1'b0;
         case (state_r)
            ST_BOOT: begin
               // Configuration is sampled one edge after reset release
               ost_cnt_r <= 11'h000;
               if (crystal) begin
                  state_r <= ST_RESET_OST;
                  if (two_speed_enable) begin
                     cur_src_r <= SRC_INTERNAL;
                     core_run_r <= 1'b1;
                     periph_run_r <= 1'b1;
                     done_pulse_r <= 1'b1;
                     done_src_r <= SRC_INTERNAL;
                  end
               end else begin
                  state_r <= ST_RUN;
                  core_run_r <= 1'b1;
                  periph_run_r <= 1'b1;
                  done_pulse_r <= 1'b1;
                  done_src_r <= SRC_PRIMARY;
               end
            end
            ST_RESET_OST: begin
               if (ost_done && cur_src_r == SRC_INTERNAL) begin
                  state_r <= ST_SETTLE;
                  core_run_r <= 1'b0;
               end else if (ost_done) begin
                  state_r <= ST_RUN;
                  cur_src_r <= SRC_PRIMARY;
                  core_run_r <= 1'b1;
                  periph_run_r <= 1'b1;
                  done_pulse_r <= 1'b1;
                  done_src_r <= SRC_PRIMARY;
               end else if (primary_tick) begin
                  ost_cnt_r <= ost_cnt_r + 11'h001;
               end
            end
            ST_RUN: begin
               if (sleep_req) begin
                  state_r <= ST_SLEEP;
                  core_run_r <= 1'b0;
                  periph_run_r <= 1'b0;
               end else if (want_src != cur_src_r) begin
                  tgt_src_r <= want_src;
                  ost_cnt_r <= 11'h000;
                  settle_cnt_r <= 4'h0;
                  if (want_src == SRC_PRIMARY && crystal) begin
                     state_r <= ST_OST_WAIT;
                  end else begin
                     state_r <= ST_SETTLE;
                     core_run_r <= 1'b0;
                  end
               end
            end
            ST_OST_WAIT: begin
               // The old source keeps clocking the core while the crystal starts
               if (sleep_req) begin
                  state_r <= ST_SLEEP;
                  core_run_r <= 1'b0;
                  periph_run_r <= 1'b0;
               end else if (want_src != SRC_PRIMARY) begin
                  state_r <= ST_RUN;
               end else if (ost_done) begin
                  state_r <= ST_SETTLE;
                  settle_cnt_r <= 4'h0;
                  core_run_r <= 1'b0;
               end else if (primary_tick) begin
                  ost_cnt_r <= ost_cnt_r + 11'h001;
               end
            end
            ST_SETTLE: begin
               if (settle_cnt_r == SETTLE_COUNT) begin
                  state_r <= ST_RUN;
                  cur_src_r <= tgt_src_r;
                  core_run_r <= 1'b1;
                  periph_run_r <= 1'b1;
                  done_pulse_r <= 1'b1;
                  done_src_r <= tgt_src_r;
               end else if (tgt_tick) begin
                  settle_cnt_r <= settle_cnt_r + 4'h1;
               end
            end
            ST_SLEEP: begin
               if (wake_event) begin
                  state_r <= ST_WAKE;
                  cpu_cnt_r <= 11'h000;
                  ost_cnt_r <= 11'h000;
                  tgt_src_r <= want_src;
                  ost_need_r <= (want_src == SRC_PRIMARY) && crystal;
               end
            end
            ST_WAKE: begin
               // The CPU timer advances every cycle, the start-up timer only on primary ticks
               if (!cpu_done) begin
                  cpu_cnt_r <= cpu_cnt_r + 11'h001;
               end
               if (primary_tick && !ost_done && ost_need_r) begin
                  ost_cnt_r <= ost_cnt_r + 11'h001;
               end
               if (cpu_done) begin
                  if (!ost_need_r) begin
                     state_r <= ST_RUN;
                     cur_src_r <= tgt_src_r;
                     core_run_r <= 1'b1;
                     periph_run_r <= 1'b1;
                     done_pulse_r <= 1'b1;
                     done_src_r <= tgt_src_r;
                     wake_pulse_r <= 1'b1;
                  end else if (ost_done) begin
                     state_r <= ST_RUN;
                     cur_src_r <= SRC_PRIMARY;
                     core_run_r <= 1'b1;
                     periph_run_r <= 1'b1;
                     done_pulse_r <= 1'b1;
                     done_src_r <= SRC_PRIMARY;
                     wake_pulse_r <= 1'b1;
                  end else if (two_speed_enable) begin
                     state_r <= ST_OST_WAIT;
                     cur_src_r <= SRC_INTERNAL;
                     tgt_src_r <= SRC_PRIMARY;
                     core_run_r <= 1'b1;
                     periph_run_r <= 1'b1;
                     done_pulse_r <= 1'b1;
                     done_src_r <= SRC_INTERNAL;
                     wake_pulse_r <= 1'b1;
                  end
               end
            end
            default: begin
               state_r <= ST_BOOT;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         start_timer_done_r <= 1'b0;
         secondary_clock_active_r <= 1'b0;
      end else if (done_pulse_r) begin
         start_timer_done_r <= (done_src_r == SRC_PRIMARY);
         secondary_clock_active_r <= (done_src_r == SRC_SECONDARY);
      end
   end

   // Counts core clocks, so the delay holds whatever frequency is selected
   always_ff @(posedge core_clk) begin
      if (reset) begin
         internal_osc_stable_r <= 1'b0;
         stable_run_r <= 1'b0;
         stable_cnt_r <= 20'h0_0000;
      end else if (done_pulse_r) begin
         internal_osc_stable_r <= 1'b0;
         stable_run_r <= (done_src_r == SRC_INTERNAL);
         stable_cnt_r <= 20'h0_0000;
      end else if (stable_pulse) begin
         internal_osc_stable_r <= 1'b1;
         stable_run_r <= 1'b0;
      end else if (stable_run_r) begin
         stable_cnt_r <= stable_cnt_r + 20'h0_0001;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, mask and request
   // ----------------------------------------------------------------
   // A new event in the clearing cycle survives the write-one-to-clear.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_status_r <= 3'h0;
      end else begin
         irq_status_r <= (irq_status_r &
            ~((bus_req.wr && bus_req.addr == ADDR_IRQ_STATUS) ? bus_req.wdata[IRQ_W-1:0] : 3'h0))
            | {stable_pulse, wake_pulse_r, done_pulse_r};
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      rdata_r <= 32'h0000_0000;
      if (!reset && bus_req.rd) begin
         case (bus_req.addr)
            ADDR_OSC_CTRL: begin
               rdata_r[SCS_LSB +: 2] <= clock_source_select_r;
               rdata_r[STD_BIT] <= start_timer_done_r;
               rdata_r[IOS_BIT] <= internal_osc_stable_r;
               rdata_r[IFS_LSB +: 3] <= internal_freq_select_r;
            end
            ADDR_SEC_CTRL: begin
               rdata_r[SEN_BIT] <= secondary_osc_enable_r;
               rdata_r[SCA_BIT] <= secondary_clock_active_r;
            end
            ADDR_IRQ_STATUS: rdata_r[IRQ_W-1:0] <= irq_status_r;
            ADDR_IRQ_MASK: rdata_r[IRQ_W-1:0] <= irq_mask_r;
            ADDR_STATE: begin
               rdata_r[1:0] <= cur_src_r;
               rdata_r[2] <= core_run_r;
               rdata_r[3] <= (state_r == ST_SLEEP) || (state_r == ST_WAKE);
            end
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   // The secondary oscillator stays up until the core has really left it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         asleep <= 1'b0;
         secondary_osc_on <= 1'b0;
      end else begin
         asleep <= (state_r == ST_SLEEP) || (state_r == ST_WAKE);
         secondary_osc_on <= secondary_osc_enable_r || (cur_src_r == SRC_SECONDARY);
      end
   end

   assign rdata = rdata_r;
   assign sys_clk_sel = cur_src_r;
   assign core_run = core_run_r;
   assign periph_run = periph_run_r;
   assign internal_freq_select = internal_freq_select_r;

endmodule

`default_nettype wire

// File: bench/clk_switch_properties.sv
// Concurrent checks on the clock switch and sleep-wake block ports
`timescale 1ns/1ns
`default_nettype none
module clk_switch_properties
   import clk_switch_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire bus_req_s bus_req,
   input wire logic two_speed_enable,
   input wire logic sleep_req,
   input wire logic wake_event,
   input wire logic [1:0] sys_clk_sel,
   input wire logic core_run,
   input wire logic periph_run,
   input wire logic asleep,
   input wire logic secondary_osc_on,
   input wire logic [2:0] internal_freq_select
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // Wake delay counter
   // ----------------------------------------------------------------
   // Counts cycles from a taken wake event until the core runs again
   logic [11:0] wake_cnt_r;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wake_cnt_r <= 12'h000;
      end else if (asleep && wake_event) begin
         wake_cnt_r <= 12'h001;
      end else if (wake_cnt_r != 12'h000 && !core_run) begin
         wake_cnt_r <= wake_cnt_r + 12'h001;
      end else begin
         wake_cnt_r <= 12'h000;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_sel_legal: assert property (sys_clk_sel != 2'h3)
      else $error("system clock select holds an unused code");
   chk_switch_settle: assert property ($changed(sys_clk_sel) && !$past(reset, 2) |->
      !$past(core_run) && !$past(core_run, 8))
      else $error("clock source changed without a held core");
   chk_secondary_on: assert property (sys_clk_sel == 2'h1 |-> secondary_osc_on)
      else $error("running from secondary oscillator while it is off");
   chk_sleep_entry: assert property (sleep_req && core_run && !asleep && !two_speed_enable
      |=> !core_run && !periph_run ##1 asleep)
      else $error("sleep request did not halt the core");
   chk_sleep_halt: assert property ($rose(asleep) |-> !core_run && !periph_run)
      else $error("core clocked while entering sleep");
   chk_wake_timer: assert property ($rose(core_run) && wake_cnt_r != 12'h000
      |-> wake_cnt_r >= 12'(CPU_CYC) - 12'h002)
      else $error("core left sleep before the start-up timer expired");
   chk_sleep_select: assert property (asleep && !core_run |-> $stable(sys_clk_sel))
      else $error("clock source moved during sleep");
   chk_freq_copy: assert property ($changed(internal_freq_select) |->
      $past(bus_req.wr) && $past(bus_req.addr) == ADDR_OSC_CTRL)
      else $error("frequency select changed without a write");
   cover property ($rose(asleep));
   cover property ($fell(asleep));
   cover property ($changed(sys_clk_sel) && sys_clk_sel == 2'h2);
endmodule
bind clock_switch_sleep_wake clk_switch_properties clk_switch_properties_inst (
   .core_clk(core_clk), .reset(reset), .bus_req(bus_req),
   .two_speed_enable(two_speed_enable), .sleep_req(sleep_req), .wake_event(wake_event),
   .sys_clk_sel(sys_clk_sel), .core_run(core_run), .periph_run(periph_run),
   .asleep(asleep), .secondary_osc_on(secondary_osc_on),
   .internal_freq_select(internal_freq_select));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the clock switch and sleep-wake block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import clk_switch_pkg::*;
   localparam int STABLE_SIM = 50;
   logic core_clk, reset, two_speed_enable, sleep_req, wake_event, irq;
   logic primary_tick, secondary_tick, internal_tick, pt_en, pt_fast;
   logic core_run, periph_run, asleep, secondary_osc_on;
   logic [1:0] sys_clk_sel;
   logic [2:0] primary_osc_config, internal_freq_select;
   logic [31:0] rdata, got;
   bus_req_s bus_req;
   int err_count, checks, n;
   clock_switch_sleep_wake #(.STABLE_WAIT(STABLE_SIM)) clock_switch_sleep_wake_inst (
      .core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
      .primary_osc_config(primary_osc_config), .two_speed_enable(two_speed_enable),
      .primary_tick(primary_tick), .secondary_tick(secondary_tick),
      .internal_tick(internal_tick), .sleep_req(sleep_req), .wake_event(wake_event),
      .sys_clk_sel(sys_clk_sel), .core_run(core_run), .periph_run(periph_run),
      .asleep(asleep), .secondary_osc_on(secondary_osc_on),
      .internal_freq_select(internal_freq_select), .irq(irq));
   // ----------------------------------------------------------------
   // Clock and oscillator ticks
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Slow sources tick every other cycle; fast mode makes the crystal outrun the CPU timer
   always @(posedge core_clk) begin
      primary_tick <= pt_en & (pt_fast | ~primary_tick);
      secondary_tick <= ~secondary_tick;
      internal_tick <= ~internal_tick;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic wait_run(input logic v, output int cnt);
      cnt = 0;
      while (core_run !== v && cnt < 5000) begin
         @(posedge core_clk);
         #1;
         cnt++;
      end
      check(32'(cnt < 5000), 32'h1);
   endtask
   task automatic switch_to(input logic [31:0] ctrl);
      wr(ADDR_OSC_CTRL, ctrl);
      wait_run(1'b0, n);
      wait_run(1'b1, n);
      check(32'(n >= 15), 32'h1);
   endtask
   task automatic sleep_wake(output int cnt);
      @(posedge core_clk);
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      wake_event <= 1'b1;
      #1;
      check(asleep, 1'b1);
      check(core_run, 1'b0);
      @(posedge core_clk);
      wake_event <= 1'b0;
      wait_run(1'b1, cnt);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_boot;
      wait_run(1'b1, n);
      check(32'(n >= 2000), 32'h1);
      check(sys_clk_sel, SCS_PRIMARY);
      rd(ADDR_OSC_CTRL, got);
      check(got, 32'h0000_0004);
      rd(8'h20, got);
      check(got, 32'h0000_0000);
      rd(ADDR_IRQ_MASK, got);
      check(got, 32'h0000_0000);
   endtask
   task automatic t_internal;
      wr(ADDR_IRQ_MASK, 32'h0000_0005);
      switch_to(32'h0000_0052);
      check(sys_clk_sel, SCS_INTERNAL);
      check(internal_freq_select, 3'h5);
      rd(ADDR_OSC_CTRL, got);
      check(got, 32'h0000_0052);
      check(irq, 1'b1);
      wr(ADDR_IRQ_STATUS, 32'h0000_0001);
      repeat (STABLE_SIM) @(posedge core_clk);
      rd(ADDR_OSC_CTRL, got);
      check(got, 32'h0000_005a);
      rd(ADDR_IRQ_STATUS, got);
      check(got, 32'h0000_0004);
      wr(ADDR_IRQ_STATUS, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      #1;
      check(irq, 1'b0);
   endtask
   task automatic t_secondary;
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      wr(ADDR_SEC_CTRL, 32'h0000_0001);
      switch_to(32'h0000_0051);
      check(sys_clk_sel, SCS_SECONDARY);
      check(secondary_osc_on, 1'b1);
      rd(ADDR_SEC_CTRL, got);
      check(got, 32'h0000_0003);
      rd(ADDR_OSC_CTRL, got);
      check(got & 32'h0000_0007, 32'h0000_0001);
      check(irq, 1'b0);
   endtask
   task automatic t_primary;
      wr(ADDR_OSC_CTRL, 32'h0000_0050);
      wait_run(1'b0, n);
      check(32'(n >= 2000), 32'h1);
      check(sys_clk_sel, SCS_SECONDARY);
      wait_run(1'b1, n);
      check(32'(n >= 15), 32'h1);
      check(sys_clk_sel, SCS_PRIMARY);
      rd(ADDR_OSC_CTRL, got);
      check(got & 32'h0000_0007, 32'h0000_0004);
   endtask
   task automatic t_sleep_primary;
      pt_fast = 1'b1;
      sleep_wake(n);
      check(32'(n >= 1240), 32'h1);
      check(32'(n < 1300), 32'h1);
      check(sys_clk_sel, SCS_PRIMARY);
      rd(ADDR_OSC_CTRL, got);
      check(got & 32'h0000_0003, 32'h0000_0000);
      rd(ADDR_IRQ_STATUS, got);
      check(got & 32'h0000_0002, 32'h0000_0002);
      pt_fast = 1'b0;
   endtask
   task automatic t_sleep_internal;
      switch_to(32'h0000_0052);
      pt_en = 1'b0;
      sleep_wake(n);
      check(32'(n < 1300), 32'h1);
      check(sys_clk_sel, SCS_INTERNAL);
      pt_en = 1'b1;
   endtask
   task automatic t_driven;
      @(posedge core_clk);
      primary_osc_config <= PCFG_DRIVEN;
      wr(ADDR_OSC_CTRL, 32'h0000_0050);
      wait_run(1'b0, n);
      check(32'(n < 3), 32'h1);
      wait_run(1'b1, n);
      check(32'(n >= 15), 32'h1);
      check(sys_clk_sel, SCS_PRIMARY);
      rd(ADDR_OSC_CTRL, got);
      check(got & 32'h0000_0007, 32'h0000_0004);
      @(posedge core_clk);
      primary_osc_config <= PCFG_LOW_POWER_CRYSTAL;
   endtask
   task automatic t_wake_two_speed;
      sleep_wake(n);
      check(32'(n >= 1240), 32'h1);
      check(32'(n < 1300), 32'h1);
      check(sys_clk_sel, SCS_INTERNAL);
      wait_run(1'b0, n);
      wait_run(1'b1, n);
      check(sys_clk_sel, SCS_PRIMARY);
   endtask
   task automatic t_two_speed;
      @(posedge core_clk);
      two_speed_enable <= 1'b1;
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check(core_run, 1'b1);
      check(sys_clk_sel, SCS_INTERNAL);
      repeat (2200) @(posedge core_clk);
      #1;
      check(sys_clk_sel, SCS_PRIMARY);
      rd(ADDR_OSC_CTRL, got);
      check(got & 32'h0000_0003, 32'h0000_0000);
   endtask
   task automatic test_done;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      bus_req = '0;
      primary_osc_config = PCFG_LOW_POWER_CRYSTAL;
      {two_speed_enable, sleep_req, wake_event, pt_fast} = 4'h0;
      {primary_tick, secondary_tick, internal_tick, pt_en} = 4'h1;
      err_count = 0;
      checks = 0;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      t_boot;
      t_internal;
      t_secondary;
      t_primary;
      t_sleep_primary;
      t_sleep_internal;
      t_driven;
      t_two_speed;
      t_wake_two_speed;
      test_done;
   end
   initial begin
      repeat (30000) @(posedge core_clk);
      err_count++;
      test_done;
   end
endmodule
`default_nettype wire
